/* File: common/coad_regs.svh */
// Offsets, keys, field positions and field codes of the option area
`ifndef COAD_REGS_SVH
`define COAD_REGS_SVH
`define COAD_OFS_CAL30 32'h1ffff048
`define COAD_OFS_CAL85 32'h1ffff04c
`define COAD_OFS_CAL105 32'h1ffff06c
`define COAD_OFS_UID0 32'hfffff050
`define COAD_OFS_UID1 32'hfffff054
`define COAD_OFS_UID2 32'hfffff058
`define COAD_OFS_UID3 32'h1ffff05c
`define COAD_OFS_RPROT 32'h1ffff200
`define COAD_OFS_WDOPT 32'h1ffff20c
`define COAD_OFS_BOROPT 32'h1ffff210
`define COAD_OFS_PGPROT 32'h1ffff214
`define COAD_AREA_LO 32'h1ffff000
`define COAD_AREA_HI 32'h1ffff67f
`define COAD_CAL_MSB 23
`define COAD_RP_KEY 28'h69c8a27
`define COAD_RP_KEY_LSB 4
`define COAD_RP_LVL_MSB 1
`define COAD_WD_OSC_MSB 15
`define COAD_WD_OSC_LSB 4
`define COAD_WD_OSC_SW 12'h96d
`define COAD_WD_OSC_DEEP 12'h0a7
`define COAD_WD_CLK_BIT 2
`define COAD_WD_RST_BIT 1
`define COAD_WD_CNT_BIT 0
`define COAD_BOR_KEY 16'h9d58
`define COAD_BOR_KEY_LSB 16
`define COAD_BOR_M_MSB 15
`define COAD_BOR_M_LSB 8
`define COAD_BOR_SW 8'haa
`define COAD_BOR_THR_MSB 2
`define COAD_PG1_BIT 0
`define COAD_PG2_BIT 1
`define COAD_PG3_BIT 2
`define COAD_ZERO 32'h00000000
`endif

/* File: common/coad_pkg.sv */
// Types shared by the option area decoder and its bench
package coad_pkg;
    typedef enum logic [1:0] {LVL0, LVL1, LVL2} coad_lvl_t;
    typedef enum logic [1:0] {SRC_DEBUG, SRC_RAM, SRC_FLASH} coad_src_t;
    typedef enum logic [1:0] {
        OP_READ, OP_PAGE_ERASE, OP_PAGE_WRITE, OP_BULK_ERASE
    } coad_op_t;
    typedef enum logic [2:0] {
        TGT_MAIN, TGT_OPT0, TGT_OPT1, TGT_OPT2, TGT_OPT3
    } coad_tgt_t;
    typedef enum logic [1:0] {
        WDOSC_SW, WDOSC_OFF_DEEP, WDOSC_OFF_SHUT
    } coad_wdosc_t;
    // Raw option words as stored in the nonvolatile area
    typedef struct packed {
        logic [31:0] cal30;
        logic [31:0] cal85;
        logic [31:0] cal105;
        logic [31:0] uid0;
        logic [31:0] uid1;
        logic [31:0] uid2;
        logic [31:0] uid3;
        logic [31:0] rprot;
        logic [31:0] wdopt;
        logic [31:0] boropt;
        logic [31:0] pgprot;
    } coad_img_t;
    // Access request from the flash controller
    typedef struct packed {
        logic valid;
        coad_src_t src;
        coad_op_t op;
        coad_tgt_t tgt;
        logic rp_update;
        coad_lvl_t new_lvl;
    } coad_req_t;
    // Decoded control settings
    typedef struct packed {
        coad_lvl_t lvl;
        coad_wdosc_t wd_osc;
        logic wd_clk_rc;
        logic wd_rst_forced;
        logic wd_cnt_forced;
        logic bor_key_ok;
        logic bor_forced;
        logic [2:0] bor_thr;
        logic [2:0] pg_writable;
    } coad_set_t;
endpackage : coad_pkg

/* File: hw/coad_top.sv */
// Option area decoder: captures option words, decodes them, gates access
`timescale 1ns/10ps
`include "coad_regs.svh"

module coad_top (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire coad_pkg::coad_img_t OPT_IMAGE,
    input wire coad_pkg::coad_req_t REQ,
    input wire logic BULK_DONE,
    output logic OPT_READY,
    output logic GRANT_VLD,
    output logic GRANT_OK,
    output coad_pkg::coad_set_t SETTINGS,
    output logic [127:0] UNIQUE_ID
);

    // ------------------------------------------------------------
    // Option word decoders
    // ------------------------------------------------------------

    // Protection level from key and level field
    function automatic coad_pkg::coad_lvl_t lvl_of(
        input logic [31:0] w
    );
        coad_pkg::coad_lvl_t l;
        l = coad_pkg::LVL2;
        if (w[31:`COAD_RP_KEY_LSB] == `COAD_RP_KEY)
        begin
            unique case (w[`COAD_RP_LVL_MSB:0])
                2'h3: l = coad_pkg::LVL0;
                2'h2: l = coad_pkg::LVL1;
                default: l = coad_pkg::LVL2;
            endcase
        end
        return l;
    endfunction : lvl_of

    // All decoded settings from the raw image
    function automatic coad_pkg::coad_set_t dec(
        input coad_pkg::coad_img_t img
    );
        coad_pkg::coad_set_t s;
        logic [11:0] osc;
        s = '0;
        osc = img.wdopt[`COAD_WD_OSC_MSB:`COAD_WD_OSC_LSB];
        s.lvl = lvl_of(img.rprot);
        // Oscillator master field
        if (osc == `COAD_WD_OSC_SW)
            s.wd_osc = coad_pkg::WDOSC_SW;
        else if (osc == `COAD_WD_OSC_DEEP)
            s.wd_osc = coad_pkg::WDOSC_OFF_DEEP;
        else
            s.wd_osc = coad_pkg::WDOSC_OFF_SHUT;
        s.wd_clk_rc = img.wdopt[`COAD_WD_CLK_BIT];
        s.wd_rst_forced = ~img.wdopt[`COAD_WD_RST_BIT];
        s.wd_cnt_forced = ~img.wdopt[`COAD_WD_CNT_BIT];
        s.bor_key_ok = img.boropt[31:`COAD_BOR_KEY_LSB]
            == `COAD_BOR_KEY;
        s.bor_forced = img.boropt[`COAD_BOR_M_MSB:`COAD_BOR_M_LSB]
            != `COAD_BOR_SW;
        s.bor_thr = img.boropt[`COAD_BOR_THR_MSB:0];
        s.pg_writable = {img.pgprot[`COAD_PG3_BIT],
            img.pgprot[`COAD_PG2_BIT],
            img.pgprot[`COAD_PG1_BIT]};
        return s;
    endfunction : dec

    // ------------------------------------------------------------
    // Capture and settings state
    // ------------------------------------------------------------

    logic grant_c;
    logic cap_q;
    logic cap_d;
    coad_pkg::coad_set_t set_q;
    coad_pkg::coad_set_t set_d;
    coad_pkg::coad_img_t img_q;
    coad_pkg::coad_img_t img_d;

    // Capture once after reset, then hold; bulk erase clears level, else a granted update sets it
    always_comb
    begin
        cap_d = 1'b1;
        img_d = img_q;
        set_d = set_q;
        if (!cap_q)
        begin
            img_d = OPT_IMAGE;
            set_d = dec(OPT_IMAGE);
        end
        else if (BULK_DONE)
            set_d.lvl = coad_pkg::LVL0;
        else if (REQ.valid && grant_c && REQ.rp_update)
            set_d.lvl = REQ.new_lvl;
    end

    // Settings registers, safest level until captured
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            cap_q <= 1'b0;
            img_q <= '0;
            set_q <= '{lvl: coad_pkg::LVL2,
                       wd_osc: coad_pkg::WDOSC_OFF_SHUT,
                       wd_clk_rc: 1'b1,
                       wd_rst_forced: 1'b1,
                       wd_cnt_forced: 1'b1,
                       bor_key_ok: 1'b0,
                       bor_forced: 1'b1,
                       bor_thr: 3'h0,
                       pg_writable: 3'h0};
        end
        else
        begin
            cap_q <= cap_d;
            img_q <= img_d;
            set_q <= set_d;
        end
    end

    assign SETTINGS = set_q;
    assign OPT_READY = cap_q;
    // Unique ID: coordinates low, lot number high
    assign UNIQUE_ID = {img_q.uid3, img_q.uid2,
        img_q.uid1, img_q.uid0};

    // ------------------------------------------------------------
    // Access gate
    // ------------------------------------------------------------

    logic restricted_c;
    logic opt_tgt_c;
    logic gvld_q;
    logic gvld_d;
    logic gok_q;
    logic gok_d;

    // Source restricted at the current level
    always_comb
    begin
        restricted_c = 1'b0;
        if (REQ.src == coad_pkg::SRC_DEBUG
            && set_q.lvl != coad_pkg::LVL0)
            restricted_c = 1'b1;
        if (REQ.src == coad_pkg::SRC_RAM
            && set_q.lvl == coad_pkg::LVL2)
            restricted_c = 1'b1;
    end

    assign opt_tgt_c = REQ.tgt != coad_pkg::TGT_MAIN;

    // Decide one request
    always_comb
    begin
        grant_c = 1'b1;
        unique case (REQ.op)
            coad_pkg::OP_READ:
                // Option area stays readable at any level
                grant_c = opt_tgt_c || !restricted_c;
            coad_pkg::OP_BULK_ERASE:
                grant_c = 1'b1;
            coad_pkg::OP_PAGE_ERASE,
            coad_pkg::OP_PAGE_WRITE:
            begin
                if (restricted_c)
                    grant_c = 1'b0;
                unique case (REQ.tgt)
                    coad_pkg::TGT_OPT0: grant_c = 1'b0;
                    coad_pkg::TGT_OPT1:
                        if (!set_q.pg_writable[0])
                            grant_c = 1'b0;
                    coad_pkg::TGT_OPT2:
                        if (!set_q.pg_writable[1])
                            grant_c = 1'b0;
                    coad_pkg::TGT_OPT3:
                        if (!set_q.pg_writable[2])
                            grant_c = 1'b0;
                    default: ;
                endcase
            end
        endcase
        if (REQ.rp_update && REQ.new_lvl < set_q.lvl)
            grant_c = 1'b0;
        if (!cap_q)
            grant_c = 1'b0;
    end

    // Answer one cycle after the request
    always_comb
    begin
        gvld_d = REQ.valid && cap_q;
        gok_d = REQ.valid && cap_q && grant_c;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            gvld_q <= 1'b0;
            gok_q <= 1'b0;
        end
        else
        begin
            gvld_q <= gvld_d;
            gok_q <= gok_d;
        end
    end

    assign GRANT_VLD = gvld_q;
    assign GRANT_OK = gok_q;

    // ------------------------------------------------------------
    // APB read port
    // ------------------------------------------------------------

    logic [31:0] rd_c;
    logic hit_c;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    // Word select; other area words read as zero
    always_comb
    begin
        rd_c = `COAD_ZERO;
        hit_c = PADDR >= `COAD_AREA_LO
            && PADDR <= `COAD_AREA_HI;
        unique case ({PADDR[31:2], 2'h0})
            `COAD_OFS_CAL30:
                rd_c[`COAD_CAL_MSB:0] =
                    img_q.cal30[`COAD_CAL_MSB:0];
            `COAD_OFS_CAL85:
                rd_c[`COAD_CAL_MSB:0] =
                    img_q.cal85[`COAD_CAL_MSB:0];
            `COAD_OFS_CAL105:
                rd_c[`COAD_CAL_MSB:0] =
                    img_q.cal105[`COAD_CAL_MSB:0];
            `COAD_OFS_UID0:
            begin
                rd_c = img_q.uid0;
                hit_c = 1'b1;
            end
            `COAD_OFS_UID1:
            begin
                rd_c = img_q.uid1;
                hit_c = 1'b1;
            end
            `COAD_OFS_UID2:
            begin
                rd_c = img_q.uid2;
                hit_c = 1'b1;
            end
            `COAD_OFS_UID3: rd_c = img_q.uid3;
            `COAD_OFS_RPROT: rd_c = img_q.rprot;
            `COAD_OFS_WDOPT: rd_c = img_q.wdopt;
            `COAD_OFS_BOROPT: rd_c = img_q.boropt;
            `COAD_OFS_PGPROT: rd_c = img_q.pgprot;
            default: ;
        endcase
    end

    // One wait state; whole word returned for any access width
    always_comb
    begin
        pready_d = PSEL && PENABLE && !pready_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d)
        begin
            prdata_d = `COAD_ZERO;
            pslverr_d = PWRITE || !hit_c;
            if (!PWRITE && hit_c)
                prdata_d = rd_c;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            prdata_q <= `COAD_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    bad_key_a: assert property (
        $rose(cap_q) && $past(OPT_IMAGE.rprot[31:4]) != `COAD_RP_KEY
        |-> set_q.lvl == coad_pkg::LVL2)
        else $error("bad key did not give level 2");

    lvl_field_a: assert property (
        $rose(cap_q) && $past(OPT_IMAGE.rprot & 32'hfffffff3) == 32'h69c8a273
        |-> set_q.lvl == coad_pkg::LVL0)
        else $error("level field 11 not level 0");

    bulk_zero_a: assert property (
        cap_q && BULK_DONE |=> set_q.lvl == coad_pkg::LVL0)
        else $error("bulk erase did not clear level");

    raise_only_a: assert property (
        cap_q && !BULK_DONE |=> set_q.lvl >= $past(set_q.lvl))
        else $error("level lowered without bulk erase");

    dbg_block_a: assert property (
        REQ.valid && cap_q && REQ.src == coad_pkg::SRC_DEBUG
        && set_q.lvl != coad_pkg::LVL0 && REQ.tgt == coad_pkg::TGT_MAIN
        && REQ.op != coad_pkg::OP_BULK_ERASE
        |=> GRANT_VLD && !GRANT_OK)
        else $error("debug access granted when protected");

    ram_block_a: assert property (
        REQ.valid && cap_q && REQ.src == coad_pkg::SRC_RAM
        && set_q.lvl == coad_pkg::LVL2 && !opt_tgt_c
        && REQ.op == coad_pkg::OP_READ |=> !GRANT_OK)
        else $error("RAM read granted at level 2");

    opt_read_a: assert property (
        REQ.valid && cap_q && REQ.op == coad_pkg::OP_READ
        && opt_tgt_c && !REQ.rp_update |=> GRANT_OK)
        else $error("option area read refused");

    bulk_ok_a: assert property (
        REQ.valid && cap_q && REQ.op == coad_pkg::OP_BULK_ERASE
        && !REQ.rp_update |=> GRANT_OK)
        else $error("bulk erase refused");

    hold_set_a: assert property (
        cap_q && !BULK_DONE && !REQ.valid ##1 !BULK_DONE && !REQ.valid
        |-> $stable(SETTINGS) [*2])
        else $error("settings changed without cause");

    wd_osc_a: assert property (
        $rose(cap_q) && $past(OPT_IMAGE.wdopt[15:4]) == 12'h0a7
        |-> set_q.wd_osc == coad_pkg::WDOSC_OFF_DEEP)
        else $error("oscillator field not decoded");

    apb_wait_a: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("read not answered in one wait");

    setup_c: cover property (PSEL && !PENABLE ##1 PENABLE ##1 PREADY);
    bulk_c: cover property (BULK_DONE && set_q.lvl == coad_pkg::LVL2);
    deny_c: cover property (GRANT_VLD && !GRANT_OK);
    raise_c: cover property (REQ.valid && REQ.rp_update ##1 GRANT_OK);

endmodule : coad_top

/* File: testbench/coad_far_end.sv */
// Far-side model: option store and flash controller requester
`timescale 1ns/10ps

module coad_far_end (
    input wire logic CLK,
    input wire logic GRANT_VLD,
    input wire logic GRANT_OK,
    output coad_pkg::coad_img_t OPT_IMAGE,
    output coad_pkg::coad_req_t REQ,
    output logic BULK_DONE
);
    // ------------------------------------------------------------
    // Idle values
    // ------------------------------------------------------------
    initial
    begin
        OPT_IMAGE = '0;
        REQ = '0;
        BULK_DONE = 1'b0;
    end

    // ------------------------------------------------------------
    // Store and request tasks
    // ------------------------------------------------------------
    // New image, only while reset is held; stays stable afterwards
    // Model never asks for deep sleep, so a forced oscillator is safe
    task automatic load(input coad_pkg::coad_img_t img);
        OPT_IMAGE <= img;
    endtask : load

    // One request; the answer stands one cycle after it is taken
    task automatic issue(input coad_pkg::coad_req_t r, output logic vld,
        output logic ok);
        @(posedge CLK);
        REQ <= r;
        @(posedge CLK);
        REQ <= '0;
        @(negedge CLK);
        vld = GRANT_VLD;
        ok = GRANT_OK;
    endtask : issue

    // Completion pulse of a bulk erase
    task automatic bulk;
        @(posedge CLK);
        BULK_DONE <= 1'b1;
        @(posedge CLK);
        BULK_DONE <= 1'b0;
    endtask : bulk
endmodule : coad_far_end

/* File: testbench/tb.sv */
// Self-checking bench for the option area decoder
`timescale 1ns/10ps

module tb;
    logic clk;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bulk_done;
    logic opt_ready;
    logic grant_vld;
    logic grant_ok;
    coad_pkg::coad_img_t img;
    coad_pkg::coad_req_t req;
    coad_pkg::coad_set_t sets;
    logic [127:0] uid;
    int fail_count;
    int checked;

    coad_top dut (
        .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(32'h5a5a5a5a),
        .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OPT_IMAGE(img), .REQ(req),
        .BULK_DONE(bulk_done), .OPT_READY(opt_ready),
        .GRANT_VLD(grant_vld), .GRANT_OK(grant_ok), .SETTINGS(sets),
        .UNIQUE_ID(uid)
    );

    coad_far_end far (
        .CLK(clk), .GRANT_VLD(grant_vld), .GRANT_OK(grant_ok),
        .OPT_IMAGE(img), .REQ(req), .BULK_DONE(bulk_done)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    task automatic check(input string what, input logic [127:0] seen,
        input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a,
        output logic [31:0] d, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Look at the answer between edges, finish at the next edge
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        d = prdata;
        err = pslverr;
        check("apb answer", pready, 1'b1);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset(input coad_pkg::coad_img_t i);
        @(posedge clk);
        rstn <= 1'b0;
        far.load(i);
        repeat (6) @(posedge clk);
        check("lvl in reset", sets.lvl, coad_pkg::LVL2);
        check("ready in reset", opt_ready, 1'b0);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset

    // Decoded settings expected from an image
    function automatic coad_pkg::coad_set_t exp_set(coad_pkg::coad_img_t i);
        coad_pkg::coad_set_t s;
        s = '0;
        if (i.rprot[31:4] != 28'h69c8a27 || i.rprot[1] == 1'b0)
            s.lvl = coad_pkg::LVL2;
        else
            s.lvl = i.rprot[0] ? coad_pkg::LVL0 : coad_pkg::LVL1;
        if (i.wdopt[15:4] == 12'h96d)
            s.wd_osc = coad_pkg::WDOSC_SW;
        else if (i.wdopt[15:4] == 12'h0a7)
            s.wd_osc = coad_pkg::WDOSC_OFF_DEEP;
        else
            s.wd_osc = coad_pkg::WDOSC_OFF_SHUT;
        s.wd_clk_rc = i.wdopt[2];
        s.wd_rst_forced = ~i.wdopt[1];
        s.wd_cnt_forced = ~i.wdopt[0];
        s.bor_key_ok = i.boropt[31:16] == 16'h9d58;
        s.bor_forced = i.boropt[15:8] != 8'haa;
        s.bor_thr = i.boropt[2:0];
        s.pg_writable = i.pgprot[2:0];
        return s;
    endfunction : exp_set

    // Grant expected for a request at a given level
    function automatic logic exp_ok(coad_pkg::coad_lvl_t l,
        coad_pkg::coad_req_t r, logic [2:0] pg);
        logic rs;
        rs = (r.src == coad_pkg::SRC_DEBUG && l != coad_pkg::LVL0) ||
            (r.src == coad_pkg::SRC_RAM && l == coad_pkg::LVL2);
        case (r.op)
            coad_pkg::OP_READ: return r.tgt != coad_pkg::TGT_MAIN || !rs;
            coad_pkg::OP_BULK_ERASE: return 1'b1;
            default:
                if (rs || r.tgt == coad_pkg::TGT_OPT0)
                    return 1'b0;
                else if (r.tgt == coad_pkg::TGT_MAIN)
                    return 1'b1;
                else
                    return pg[r.tgt - 3'd2];
        endcase
    endfunction : exp_ok

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        coad_pkg::coad_req_t r;
        coad_pkg::coad_set_t e;
        coad_pkg::coad_img_t im;
        logic v;
        logic k;
        logic err;
        logic [31:0] d;
        logic [31:0] w;
        logic [31:0] adr [11];
        fail_count = 0;
        checked = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        adr = '{32'h1ffff048, 32'h1ffff04c, 32'h1ffff06c, 32'hfffff050,
            32'hfffff054, 32'hfffff058, 32'h1ffff05c, 32'h1ffff200,
            32'h1ffff20c, 32'h1ffff210, 32'h1ffff214};
        void'($urandom(32'h93e9));
        for (int n = 0; n < 8; n++)
        begin
            for (int b = 0; b < 11; b++)
                im[b * 32 +: 32] = $urandom;
            if (n < 4)
                im.rprot[31:4] = 28'h69c8a27;
            im.rprot[1:0] = 2'(n);
            if (n < 2)
                im.wdopt[15:4] = n ? 12'h0a7 : 12'h96d;
            if (n == 0)
                im.boropt[31:8] = 24'h9d58aa;
            im.boropt[2:0] = 3'(n);
            do_reset(im);
            e = exp_set(im);
            check("settings", sets, e);
            check("ready", opt_ready, 1'b1);
            check("unique id", uid, {im.uid3, im.uid2, im.uid1,
                im.uid0});
            for (int a = 0; a < 11; a++)
            begin
                apb(1'b0, adr[a], d, err);
                w = im[(10 - a) * 32 +: 32];
                check("read data", d, a < 3 ? w & 32'h00ffffff : w);
                check("read error", err, 1'b0);
            end
            for (int s = 0; s < 3; s++)
                for (int o = 0; o < 4; o++)
                    for (int t = 0; t < 5; t++)
                    begin
                        r = '0;
                        r.valid = 1'b1;
                        r.src = coad_pkg::coad_src_t'(s);
                        r.op = coad_pkg::coad_op_t'(o);
                        r.tgt = coad_pkg::coad_tgt_t'(t);
                        far.issue(r, v, k);
                        check("grant valid", v, 1'b1);
                        check("grant", k, exp_ok(e.lvl, r,
                            e.pg_writable));
                    end
            r = '0;
            r.valid = 1'b1;
            r.src = coad_pkg::SRC_FLASH;
            r.rp_update = 1'b1;
            r.new_lvl = coad_pkg::LVL0;
            far.issue(r, v, k);
            check("lower", k, e.lvl == coad_pkg::LVL0);
            check("level kept", sets.lvl, e.lvl);
            r.new_lvl = coad_pkg::LVL2;
            far.issue(r, v, k);
            check("raise", k, 1'b1);
            check("level raised", sets.lvl, coad_pkg::LVL2);
            far.bulk();
            @(posedge clk);
            check("after bulk", sets.lvl, coad_pkg::LVL0);
            check("held", sets.wd_osc, e.wd_osc);
        end
        apb(1'b1, adr[0], d, err);
        check("write refused", err, 1'b1);
        apb(1'b0, 32'h00000000, d, err);
        check("unmapped error", err, 1'b1);
        check("unmapped data", d, 32'h00000000);
        stop_test();
    end
endmodule : tb
